// file: pcch_pkg.sv
`default_nettype none
// ==========================================================
// configuration header constants
package pcch_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLASS_REV = 8'h08;
  localparam logic [7:0] OFS_CLS_LAT = 8'h0C;
  localparam logic [7:0] OFS_WIN_BASE = 8'h10;
  localparam logic [7:0] OFS_INT_GNT = 8'h3C;

  // ==========================================================
  // fixed field values
  localparam logic [7:0] BASE_CLASS = 8'h02;
  localparam logic [7:0] SUB_CLASS = 8'h80;
  localparam logic [7:0] PROG_IF = 8'h00;
  localparam logic [6:0] HEADER_LAYOUT = 7'h00;
  localparam logic MULTIFUNCTION = 1'b0;
  localparam logic [7:0] INT_PIN_CODE = 8'h01;
  localparam logic [7:0] MIN_GRANT_CODE = 8'h05;
  localparam logic [7:0] MAX_LAT_CODE = 8'h0F;
  localparam logic [1:0] DEVSEL_TIMING = 2'h1;
  localparam logic FAST_B2B_CAP = 1'b1;
  localparam logic [3:0] WIN_LOW_BITS = 4'h0;

  // ==========================================================
  // field positions
  localparam int PAR_FLAG_BIT = 31;
  localparam int DEVSEL_LSB = 25;
  localparam int FAST_B2B_BIT = 23;
  localparam int PREN_BIT = 6;
  localparam int MEN_BIT = 1;
  localparam int WIN_LSB = 12;
  localparam int WIN_W = 32 - WIN_LSB;

  // ==========================================================
  // reset values
  localparam logic [7:0] CLS_RST = 8'h00;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  localparam logic [WIN_W-1:0] WIN_BASE_RST = 20'h0_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // timing: grant and latency fields count 250 ns units
  localparam int GRANT_UNIT_NS = 250;
  localparam int CLK_PERIOD_NS = 50;
  localparam int GRANT_UNIT_CYCLES = GRANT_UNIT_NS / CLK_PERIOD_NS;

  // ==========================================================
  // master read commands
  typedef logic [3:0] pcch_rdcmd_type;
  localparam pcch_rdcmd_type CMD_MEM_READ = 4'h6;
  localparam pcch_rdcmd_type CMD_MEM_READ_LINE = 4'hE;
  localparam pcch_rdcmd_type CMD_MEM_READ_MULT = 4'hC;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcch_cfg_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } pcch_mem_req_type;

endpackage
`default_nettype wire

// file: pcch_read_cmd.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// master read command selection from transfer size
module pcch_read_cmd #(
  parameter int LEN_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic [LEN_W-1:0] req_len,
  input wire logic [7:0] cacheline_size_field,
  output logic cmd_valid_r,
  output pcch_pkg::pcch_rdcmd_type cmd_r
);

  initial begin
    if (LEN_W < 8) begin
      $error("length width must cover the cacheline size");
    end
  end

  // ==========================================================
  // single dword, within a line, or beyond a line
  wire logic is_single = (req_len == LEN_W'(1));
  wire logic within_line = (req_len <= LEN_W'(cacheline_size_field));
  wire pcch_pkg::pcch_rdcmd_type cmd_nxt = is_single ? pcch_pkg::CMD_MEM_READ :
    within_line ? pcch_pkg::CMD_MEM_READ_LINE : pcch_pkg::CMD_MEM_READ_MULT;

  // registered so the command settles with its valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_r <= 1'b0;
      cmd_r <= pcch_pkg::CMD_MEM_READ;
    end else begin
      cmd_valid_r <= req_valid;
      cmd_r <= cmd_nxt;
    end
  end

endmodule
`default_nettype wire

// file: pcch_mem_window.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// 4k memory window claim
module pcch_mem_window #(
  parameter int BASE_W = 20
) (
  input wire pcch_pkg::pcch_mem_req_type mem_req,
  input wire logic memory_space_enable,
  input wire logic [BASE_W-1:0] base_address_field,
  output logic mem_claim
);

  initial begin
    if (BASE_W != pcch_pkg::WIN_W) begin
      $error("base width must match the 4k window");
    end
  end

  // ==========================================================
  // combinational claim; only upper address bits compared
  wire logic addr_hit = (mem_req.addr[31:pcch_pkg::WIN_LSB] == base_address_field);
  assign mem_claim = mem_req.valid & memory_space_enable & addr_hit;

endmodule
`default_nettype wire

// file: pcch_config_header.sv
//Behaviour
// - parity error flag sets on any detected parity error, even if reporting off
// - class register is read-only: 02, 80, 00, revision
// - master read: one dword Memory Read, within line Read Line, else Multiple
// - cacheline size bits 7:0, latency timer 15:8, writable, reset zero
// - header layout bits 22:16 read fixed code, upper byte reads zero
// - multifunction bit 23 reads low
// - window base bit 0 low, bits 2:1 read 00
// - prefetchable bit 3 reads low
// - base bits 11:4 read zero, bits 31:12 writable, reset zero
// - memory mapping only, gated by the memory space enable
// - interrupt line bits 7:0 writable, reset zero
// - interrupt pin field reads 01
// - min grant reads 05, max latency reads 0F, 250 ns units
// - configuration registers reachable only during a selected config cycle
// - status bits clear by writing one, zero leaves them
// - writable bits reset to zero, read-only writes ignored
`timescale 1ns/100ps
`default_nettype none
module pcch_config_header #(
  parameter int LEN_W = 8,
  parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pcch_pkg::pcch_cfg_req_type cfg_req,
  output logic [31:0] cfg_rdata_r,
  output logic cfg_ack_r,
  input wire logic parity_err_detect,
  input wire pcch_pkg::pcch_mem_req_type mem_req,
  output logic mem_claim,
  input wire logic rd_req_valid,
  input wire logic [LEN_W-1:0] rd_req_len,
  output logic rd_cmd_valid_r,
  output pcch_pkg::pcch_rdcmd_type rd_cmd_r,
  output logic memory_space_enable,
  output logic parity_report_enable,
  output logic [7:0] latency_timer_field,
  output logic [7:0] interrupt_line_field
);

  initial begin
    if (LEN_W < 8 || LEN_W > 16) begin
      $error("transfer length width out of range");
    end
  end

  // ==========================================================
  // byte-lane merge used by the cacheline, latency, interrupt line and upper window base bytes
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic en);
    lane_merge = en ? new_v : old_v;
  endfunction

  // ==========================================================
  // state
  logic parity_error_flag_r;
  logic pren_r;
  logic men_r;
  logic [7:0] cls_r;
  logic [7:0] lat_r;
  logic [pcch_pkg::WIN_W-1:0] base_r;
  logic [7:0] int_line_r;

  // ==========================================================
  // access qualification: only while the config select is up
  wire logic cfg_rd = cfg_req.sel & cfg_req.rd;
  wire logic cfg_wr = cfg_req.sel & cfg_req.wr & ~cfg_req.rd;
  wire logic [7:0] ofs = {cfg_req.offset[7:2], 2'b00};
  wire logic hit_cmd = (ofs == pcch_pkg::OFS_CMD_STATUS);
  wire logic hit_class = (ofs == pcch_pkg::OFS_CLASS_REV);
  wire logic hit_cls = (ofs == pcch_pkg::OFS_CLS_LAT);
  wire logic hit_base = (ofs == pcch_pkg::OFS_WIN_BASE);
  wire logic hit_int = (ofs == pcch_pkg::OFS_INT_GNT);
  wire logic [31:0] wd = cfg_req.wdata;
  wire logic [3:0] be = cfg_req.be;

  // ==========================================================
  // write strobes; read-only registers have none at all
  wire logic wr_cmd = cfg_wr & hit_cmd;
  wire logic wr_cls = cfg_wr & hit_cls;
  wire logic wr_base = cfg_wr & hit_base;
  wire logic wr_int = cfg_wr & hit_int;

  // ==========================================================
  // next values
  // the detect wins over a same-cycle clear so no error is lost
  wire logic par_flag_clr = wr_cmd & be[3] & wd[pcch_pkg::PAR_FLAG_BIT];
  wire logic parity_error_flag_nxt = parity_err_detect |
    (parity_error_flag_r & ~par_flag_clr);
  wire logic pren_nxt = (wr_cmd & be[0]) ? wd[pcch_pkg::PREN_BIT] : pren_r;
  wire logic men_nxt = (wr_cmd & be[0]) ? wd[pcch_pkg::MEN_BIT] : men_r;
  wire logic [7:0] cls_nxt = lane_merge(cls_r, wd[7:0], wr_cls & be[0]);
  wire logic [7:0] lat_nxt = lane_merge(lat_r, wd[15:8], wr_cls & be[1]);
  wire logic [pcch_pkg::WIN_W-1:0] base_nxt = {
    lane_merge(base_r[19:12], wd[31:24], wr_base & be[3]),
    lane_merge(base_r[11:4], wd[23:16], wr_base & be[2]),
    (wr_base & be[1]) ? wd[15:12] : base_r[3:0]
  };
  wire logic [7:0] int_line_nxt = lane_merge(int_line_r, wd[7:0], wr_int & be[0]);

  // ==========================================================
  // read images
  // status half: flag 31, device select timing 26:25, fast back-to-back 23
  wire logic [31:0] img_cmd = {parity_error_flag_r, 4'h0, pcch_pkg::DEVSEL_TIMING, 1'b0,
    pcch_pkg::FAST_B2B_CAP, 7'h00, 9'h000, pren_r, 4'h0, men_r, 1'b0};
  wire logic [31:0] img_class = {pcch_pkg::BASE_CLASS, pcch_pkg::SUB_CLASS,
    pcch_pkg::PROG_IF, REVISION};
  wire logic [31:0] img_cls = {8'h00, pcch_pkg::MULTIFUNCTION, pcch_pkg::HEADER_LAYOUT,
    lat_r, cls_r};
  // low nibble: memory space, 32-bit anywhere, not prefetchable
  wire logic [31:0] img_base = {base_r, 8'h00, pcch_pkg::WIN_LOW_BITS};
  wire logic [31:0] img_int = {pcch_pkg::MAX_LAT_CODE, pcch_pkg::MIN_GRANT_CODE,
    pcch_pkg::INT_PIN_CODE, int_line_r};
  // unmapped offsets read as zero
  wire logic [31:0] rd_mux = hit_cmd ? img_cmd :
                             hit_class ? img_class :
                             hit_cls ? img_cls :
                             hit_base ? img_base :
                             hit_int ? img_int : 32'h0000_0000;

  // ==========================================================
  // status and command registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      parity_error_flag_r <= 1'b0;
      pren_r <= 1'b0;
      men_r <= 1'b0;
    end else begin
      parity_error_flag_r <= parity_error_flag_nxt;
      pren_r <= pren_nxt;
      men_r <= men_nxt;
    end
  end

  // header writable fields, all zero out of reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cls_r <= pcch_pkg::CLS_RST;
      lat_r <= pcch_pkg::LAT_RST;
      base_r <= pcch_pkg::WIN_BASE_RST;
      int_line_r <= pcch_pkg::INT_LINE_RST;
    end else begin
      cls_r <= cls_nxt;
      lat_r <= lat_nxt;
      base_r <= base_nxt;
      int_line_r <= int_line_nxt;
    end
  end

  // read data and acknowledge, one cycle after the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_r <= pcch_pkg::RDATA_RST;
      cfg_ack_r <= 1'b0;
    end else begin
      cfg_rdata_r <= cfg_rd ? rd_mux : pcch_pkg::RDATA_RST;
      cfg_ack_r <= cfg_rd | cfg_wr;
    end
  end

  // ==========================================================
  // outputs to the rest of the interface
  assign memory_space_enable = men_r;
  assign parity_report_enable = pren_r;
  assign latency_timer_field = lat_r;
  assign interrupt_line_field = int_line_r;

  // ==========================================================
  // sub-blocks
  pcch_read_cmd #(
    .LEN_W(LEN_W)
  ) u_read_cmd (
    .clk(clk),
    .reset_n(reset_n),
    .req_valid(rd_req_valid),
    .req_len(rd_req_len),
    .cacheline_size_field(cls_r),
    .cmd_valid_r(rd_cmd_valid_r),
    .cmd_r(rd_cmd_r)
  );

  pcch_mem_window #(
    .BASE_W(pcch_pkg::WIN_W)
  ) u_mem_window (
    .mem_req(mem_req),
    .memory_space_enable(men_r),
    .base_address_field(base_r),
    .mem_claim(mem_claim)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_PAR_FLAG_SETS: assert property (
    parity_err_detect |=> parity_error_flag_r ##1 (parity_error_flag_r || $past(par_flag_clr)))
    else $error("parity error flag not set by detect");

  AST_CLASS_RO: assert property (
    cfg_rd && hit_class |=> cfg_rdata_r == {8'h02, 8'h80, 8'h00, REVISION})
    else $error("class register read wrong");

  AST_RDCMD_SINGLE: assert property (
    rd_req_valid && rd_req_len == LEN_W'(1) |=> rd_cmd_valid_r && rd_cmd_r == 4'h6)
    else $error("single dword read must use memory read");

  AST_RDCMD_MULT: assert property (
    rd_req_valid && rd_req_len > LEN_W'(cls_r) && rd_req_len != LEN_W'(1)
    |=> rd_cmd_r == 4'hC)
    else $error("long read must use read multiple");

  AST_CLS_WRITE: assert property (
    wr_cls && be[1:0] == 2'b11 |=> {lat_r, cls_r} == $past(wd[15:0]))
    else $error("cacheline or latency write lost");

  AST_HDR_FIXED: assert property (
    cfg_rd && hit_cls |=> cfg_rdata_r[31:16] == 16'h0000)
    else $error("header layout or multifunction bits nonzero");

  AST_BASE_LOW: assert property (
    cfg_rd && hit_base |=> cfg_rdata_r[11:0] == 12'h000 &&
    cfg_rdata_r[31:12] == $past(base_r))
    else $error("window base read wrong");

  AST_INT_FIXED: assert property (
    cfg_rd && hit_int |=> cfg_rdata_r[31:8] == 24'h0F_0501)
    else $error("interrupt pin or grant fields wrong");

  AST_NO_SEL: assert property (
    !cfg_req.sel ##1 !cfg_req.sel |-> !cfg_ack_r && cfg_rdata_r == 32'h0000_0000)
    else $error("access answered without config select");

  AST_PAR_FLAG_W1C: assert property (
    parity_error_flag_r && par_flag_clr && !parity_err_detect |=> !parity_error_flag_r)
    else $error("parity flag not cleared by write of one");

  AST_PAR_FLAG_HOLD: assert property (
    parity_error_flag_r && !par_flag_clr |=> parity_error_flag_r)
    else $error("parity flag lost without a clear");

  AST_CLAIM: assert property (
    mem_claim |-> men_r && mem_req.addr[31:12] == base_r)
    else $error("memory cycle claimed outside window");

  AST_MULTIFUNC_LOW: assert property (
    cfg_rd && hit_cls |=> !cfg_rdata_r[23])
    else $error("multifunction bit reads high");

  AST_SPACE_TYPE: assert property (
    cfg_rd && hit_base |=> cfg_rdata_r[2:0] == 3'h0)
    else $error("window space or type bits nonzero");

  AST_NO_PREFETCH: assert property (
    cfg_rd && hit_base |=> !cfg_rdata_r[3])
    else $error("window reads prefetchable");

  AST_RDCMD_LINE: assert property (
    rd_req_valid && rd_req_len != LEN_W'(1) && rd_req_len <= LEN_W'(cls_r)
    |=> rd_cmd_r == 4'hE)
    else $error("short read must use read line");

  AST_RDCMD_VALID: assert property (
    rd_req_valid |=> rd_cmd_valid_r)
    else $error("read command valid missing");

  AST_LAT_HOLD: assert property (
    !wr_cls |=> $stable(lat_r) && $stable(cls_r))
    else $error("cacheline or latency changed without a write");

  AST_BASE_WRITE: assert property (
    wr_base && be == 4'hF |=> base_r == $past(wd[31:12]))
    else $error("window base write lost");

  AST_MEN_WRITE: assert property (
    wr_cmd && be[0] |=> men_r == $past(wd[pcch_pkg::MEN_BIT]))
    else $error("memory space enable write lost");

  AST_INT_LINE_WRITE: assert property (
    wr_int && be[0] |=> int_line_r == $past(wd[7:0]))
    else $error("interrupt line write lost");

  AST_ACK_PULSE: assert property (
    cfg_rd || cfg_wr |=> cfg_ack_r)
    else $error("selected access not acknowledged");

  AST_RDATA_IDLE: assert property (
    !cfg_rd |=> cfg_rdata_r == 32'h0000_0000)
    else $error("read data not idle after non-read cycle");

  // host accesses come every other cycle, so the read-back follows two edges later
  COV_SIZE_BASE: cover property (wr_base && wd == 32'hFFFF_FFFF ##2 cfg_rd && hit_base);
  COV_CLAIM: cover property (mem_claim);
  COV_PAR_FLAG_RACE: cover property (parity_err_detect && par_flag_clr);
  COV_PAR_FLAG_CLEAR: cover property (parity_error_flag_r && par_flag_clr);
  COV_READ_LINE: cover property (rd_cmd_valid_r && rd_cmd_r == 4'hE);

endmodule
`default_nettype wire

// file: pcch_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// host side: configuration and memory address cycles
module pcch_host_model (
  input wire logic clk,
  input wire logic [31:0] cfg_rdata_r,
  input wire logic cfg_ack_r,
  input wire logic mem_claim,
  output var pcch_pkg::pcch_cfg_req_type cfg_req,
  output var pcch_pkg::pcch_mem_req_type mem_req
);
  // idle bus at time zero
  initial begin
    cfg_req = '0;
    mem_req = '0;
  end
  // one config cycle; released lines carry inverted values so stale data never matches
  task automatic xfer(input logic s, input logic w, input logic [7:0] o, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q, output logic a);
    @(posedge clk);
    cfg_req <= '{sel: s, rd: !w, wr: w, offset: o, be: b, wdata: d};
    @(posedge clk);
    cfg_req <= '{sel: 1'b0, rd: 1'b0, wr: 1'b0, offset: ~o, be: ~b, wdata: ~d};
    #1;
    q = cfg_rdata_r;
    a = cfg_ack_r;
  endtask
  // one address phase; claim is combinational so it is looked at 1 ns after the edge
  task automatic probe(input logic v, input logic [31:0] adr, output logic c);
    @(posedge clk);
    mem_req <= '{valid: v, addr: adr};
    #1;
    c = mem_claim;
    @(posedge clk);
    mem_req <= '{valid: 1'b0, addr: ~adr};
  endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] REV = 8'h5A; // arbitrary revision value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic parity_err_detect = 1'b0;
  logic rd_req_valid = 1'b0;
  logic [7:0] rd_req_len = 8'h00;
  pcch_pkg::pcch_cfg_req_type cfg_req;
  pcch_pkg::pcch_mem_req_type mem_req;
  pcch_pkg::pcch_rdcmd_type rd_cmd_r;
  logic [31:0] cfg_rdata_r;
  logic cfg_ack_r, mem_claim, rd_cmd_valid_r, memory_space_enable, parity_report_enable;
  logic [7:0] latency_timer_field, interrupt_line_field;
  logic [31:0] q;
  logic a;
  int fail_count = 0;
  int cmp_count = 0;
  // ==========================================================
  // clock, design and host
  always #25 clk = ~clk;
  pcch_config_header #(.LEN_W(8), .REVISION(REV)) dut_u (.clk(clk), .reset_n(reset_n),
    .cfg_req(cfg_req), .cfg_rdata_r(cfg_rdata_r), .cfg_ack_r(cfg_ack_r),
    .parity_err_detect(parity_err_detect), .mem_req(mem_req), .mem_claim(mem_claim),
    .rd_req_valid(rd_req_valid), .rd_req_len(rd_req_len), .rd_cmd_valid_r(rd_cmd_valid_r),
    .rd_cmd_r(rd_cmd_r), .memory_space_enable(memory_space_enable),
    .parity_report_enable(parity_report_enable), .latency_timer_field(latency_timer_field),
    .interrupt_line_field(interrupt_line_field));
  pcch_host_model host_u (.clk(clk), .cfg_rdata_r(cfg_rdata_r), .cfg_ack_r(cfg_ack_r),
    .mem_claim(mem_claim), .cfg_req(cfg_req), .mem_req(mem_req));
  // ==========================================================
  // shared helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cw(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    host_u.xfer(1'b1, 1'b1, o, b, d, q, a);
    check("write ack", {31'h0, a}, 32'h1);
  endtask
  task automatic cr(input logic [7:0] o, input logic [31:0] exp);
    host_u.xfer(1'b1, 1'b0, o, 4'hF, 32'h0, q, a);
    check("read ack", {31'h0, a}, 32'h1);
    check("read data", q, exp);
  endtask
  // ==========================================================
  // scenarios
  // reset values, unmapped offset, unselected access
  task automatic t_reset();
    cr(8'h08, {8'h02, 8'h80, 8'h00, REV});
    cr(8'h0C, 32'h0000_0000);
    cr(8'h10, 32'h0000_0000);
    cr(8'h3C, 32'h0F05_0100);
    cr(8'h20, 32'h0000_0000);
    host_u.xfer(1'b0, 1'b0, 8'h08, 4'hF, 32'h0, q, a);
    check("unselected ack", {31'h0, a}, 32'h0);
    check("unselected data", q, 32'h0);
  endtask
  // all-ones writes: only writable bits take, byte lanes respected
  task automatic t_fields();
    cw(8'h08, 4'hF, 32'hFFFF_FFFF);
    cr(8'h08, {8'h02, 8'h80, 8'h00, REV});
    cw(8'h0C, 4'hF, 32'hFFFF_FFFF);
    cr(8'h0C, 32'h0000_FFFF);
    check("latency port", {24'h0, latency_timer_field}, 32'h0000_00FF);
    cw(8'h0C, 4'h1, 32'h0000_0000);
    cr(8'h0C, 32'h0000_FF00);
    host_u.xfer(1'b0, 1'b1, 8'h0C, 4'hF, 32'h0, q, a);
    cr(8'h0C, 32'h0000_FF00);
    cw(8'h3C, 4'hF, 32'hFFFF_FFFF);
    cr(8'h3C, 32'h0F05_01FF);
    check("int line port", {24'h0, interrupt_line_field}, 32'h0000_00FF);
  endtask
  // window sizing, placement, then claim gated by enable and match
  task automatic t_window();
    logic c;
    cw(8'h10, 4'hF, 32'hFFFF_FFFF);
    cr(8'h10, 32'hFFFF_F000);
    cw(8'h10, 4'hF, 32'h1234_5678);
    cr(8'h10, 32'h1234_5000);
    host_u.probe(1'b1, 32'h1234_5010, c);
    check("claim disabled", {31'h0, c}, 32'h0);
    cw(8'h04, 4'h1, 32'h0000_0002);
    check("mem enable", {31'h0, memory_space_enable}, 32'h1);
    host_u.probe(1'b1, 32'h1234_5FFC, c);
    check("claim hit", {31'h0, c}, 32'h1);
    host_u.probe(1'b1, 32'h1234_6000, c);
    check("claim miss", {31'h0, c}, 32'h0);
    host_u.probe(1'b0, 32'h1234_5000, c);
    check("claim idle", {31'h0, c}, 32'h0);
  endtask
  // flag sets with reporting off; only a written one clears it
  task automatic t_parity();
    check("report enable", {31'h0, parity_report_enable}, 32'h0);
    @(posedge clk);
    parity_err_detect <= 1'b1;
    @(posedge clk);
    parity_err_detect <= 1'b0;
    host_u.xfer(1'b1, 1'b0, 8'h04, 4'hF, 32'h0, q, a);
    check("flag set", {31'h0, q[31]}, 32'h1);
    cw(8'h04, 4'hF, 32'h0000_0002);
    host_u.xfer(1'b1, 1'b0, 8'h04, 4'hF, 32'h0, q, a);
    check("flag kept", {31'h0, q[31]}, 32'h1);
    cw(8'h04, 4'hF, 32'h8000_0002);
    host_u.xfer(1'b1, 1'b0, 8'h04, 4'hF, 32'h0, q, a);
    check("flag cleared", {31'h0, q[31]}, 32'h0);
    cw(8'h04, 4'h1, 32'h0000_0042);
    check("report enable on", {31'h0, parity_report_enable}, 32'h1);
    check("mem enable kept", {31'h0, memory_space_enable}, 32'h1);
  endtask
  // read command against a cacheline of 4, boundaries included
  task automatic t_readcmd();
    logic [7:0] lens [5] = '{8'h01, 8'h04, 8'h00, 8'h05, 8'h02};
    pcch_pkg::pcch_rdcmd_type exp;
    cw(8'h0C, 4'h1, 32'h0000_0004);
    foreach (lens[i]) begin
      exp = (lens[i] == 8'h01) ? pcch_pkg::CMD_MEM_READ :
            (lens[i] <= 8'h04) ? pcch_pkg::CMD_MEM_READ_LINE : pcch_pkg::CMD_MEM_READ_MULT;
      @(posedge clk);
      rd_req_valid <= 1'b1;
      rd_req_len <= lens[i];
      @(posedge clk);
      rd_req_valid <= 1'b0;
      #1;
      check("cmd valid", {31'h0, rd_cmd_valid_r}, 32'h1);
      check("cmd code", {28'h0, rd_cmd_r}, {28'h0, exp});
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_window();
    t_parity();
    t_readcmd();
    conclude();
  end
  // watchdog: the run needs under a hundred cycles, so 2000 means a hang
  initial begin
    #(50 * 2000);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
